/* File: src/pcr_pkg.sv */
// Function
// - Host reads and writes the persistent word through dedicated commands; device stores and returns it.
// - On power-on and every reset the persistent word is copied into the internal configuration.
// - Bits 15:12 give quick-read dummy cycles 1..15; 0000 acts like default 1111.
// - Bits 11:9 pick the execute-in-place read mode entered after power-on reset.
// - Bit 5 low enables double-rate transfers on both clock edges; high keeps single rate.
// - Bit 4 high lets data line three act as hold or reset input.
// - Bit 3 low enables the four-line 4-4-4 command protocol.
// - Bit 2 low enables the two-line 2-2-2 command protocol.
// - With bits 2 and 3 both low, the four-line protocol wins over dual.
// - Bit 1 picks the power-on 128Mb segment: low means highest, high means lowest.
// - Bit 0 low selects 4-byte addressing, high selects 3-byte addressing.
// - In 3-byte mode segment bits 1:0 supply address bits 25:24.
// - In 4-byte mode the segment selection is ignored when forming addresses.
// - A volatile configuration write replaces dummy count, execute-in-place enable and wrap right after the command completes, except in the reload cycle.
package pcr_pkg;

    // Persistent word field positions.
    localparam int PCR_DUMMY_HI = 15;
    localparam int PCR_DUMMY_LO = 12;
    localparam int PCR_EXEC_HI = 11;
    localparam int PCR_EXEC_LO = 9;
    localparam int PCR_DTR_BIT = 5;
    localparam int PCR_HOLD_BIT = 4;
    localparam int PCR_QUAD_BIT = 3;
    localparam int PCR_DUAL_BIT = 2;
    localparam int PCR_SEG_BIT = 1;
    localparam int PCR_ADDR_BIT = 0;

    // Volatile configuration byte field positions.
    localparam int PCR_VDUMMY_HI = 7;
    localparam int PCR_VDUMMY_LO = 4;
    localparam int PCR_VEXEC_BIT = 3;
    localparam int PCR_VWRAP_HI = 1;
    localparam int PCR_VWRAP_LO = 0;

    // Values after reset and field codes.
    localparam logic [15:0] PCR_NV_RESET = 16'hffff;
    localparam logic [3:0] PCR_DUMMY_DEFAULT = 4'hf;
    localparam logic [3:0] PCR_DUMMY_ALIAS = 4'h0;
    localparam logic [2:0] PCR_EXEC_LAST_MODE = 3'h4;
    localparam logic [2:0] PCR_EXEC_OFF = 3'h7;
    localparam logic [1:0] PCR_SEG_LOWEST = 2'h0;
    localparam logic [1:0] PCR_SEG_HIGHEST = 2'h3;
    localparam logic [1:0] PCR_WRAP_CONT = 2'h3;
    localparam logic [25:0] PCR_ADDR_RESET = 26'h0000000;
    localparam logic [15:0] PCR_RD_RESET = 16'h0000;

endpackage

/* File: src/pcr_nv_store.sv */
`timescale 1ns/10ps
module pcr_nv_store
    import pcr_pkg::*;
(
    // Clock and power-on reset.
    input wire logic clk_i,
    input wire logic por_i,
    // Store request.
    input wire logic wr_i,
    input wire logic [15:0] wr_data_i,
    // Stored word.
    output logic [15:0] word_o
);
    import pcr_pkg::*;

    typedef struct packed {
        logic [15:0] word;
    } pcr_nv_s;

    pcr_nv_s st;
    pcr_nv_s next_st;

    // The word survives ordinary resets; only power-on returns it to the erased value.
    always_comb begin
        next_st = st;
        if (wr_i) begin
            next_st.word = wr_data_i;
        end
    end

    // State register.
    always_ff @(posedge clk_i or posedge por_i) begin
        if (por_i) begin
            st.word <= PCR_NV_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign word_o = st.word;

endmodule // pcr_nv_store

/* File: src/pcr_config.sv */
`timescale 1ns/10ps
module pcr_config
    import pcr_pkg::*;
(
    // Clock and resets.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    // Persistent word commands.
    input wire logic nv_wr_i,
    input wire logic [15:0] nv_wr_data_i,
    input wire logic nv_rd_i,
    output logic [15:0] nv_rd_data_o,
    output logic nv_rd_valid_o,
    // Volatile configuration and segment writes.
    input wire logic vol_wr_i,
    input wire logic [7:0] vol_wr_data_i,
    input wire logic seg_wr_i,
    input wire logic [1:0] seg_wr_data_i,
    // Address forming.
    input wire logic [31:0] cmd_addr_i,
    output logic [25:0] mem_addr_o,
    // Active configuration.
    output logic [3:0] dummy_cycles_o,
    output logic execute_in_place_o,
    output logic [2:0] execute_in_place_mode_o,
    output logic dtr_enable_o,
    output logic data_line_three_ctrl_o,
    output logic quad_proto_o,
    output logic dual_proto_o,
    output logic [1:0] seg_sel_o,
    output logic addr_4byte_o,
    output logic [1:0] wrap_o,
    output logic load_busy_o
);
    import pcr_pkg::*;

    typedef struct packed {
        logic load_pend;
        logic [3:0] dummy;
        logic exec_en;
        logic [2:0] exec_mode;
        logic dtr_en;
        logic hold_en;
        logic quad;
        logic dual;
        logic [1:0] seg;
        logic addr4;
        logic [1:0] wrap;
        logic [15:0] rd_data;
        logic rd_valid;
        logic [25:0] mem_addr;
    } pcr_cfg_s;

    pcr_cfg_s st;
    pcr_cfg_s next_st;
    logic [15:0] nv_word;
    logic [3:0] nv_dummy;
    logic [2:0] nv_exec;
    logic [3:0] vol_dummy;

    // Nonvolatile storage of the persistent word.
    pcr_nv_store u_store (
        .clk_i(clk_i),
        .por_i(por_i),
        .wr_i(nv_wr_i),
        .wr_data_i(nv_wr_data_i),
        .word_o(nv_word)
    );

    // Field slices of the stored word and of the volatile byte.
    assign nv_dummy = nv_word[PCR_DUMMY_HI:PCR_DUMMY_LO];
    assign nv_exec = nv_word[PCR_EXEC_HI:PCR_EXEC_LO];
    assign vol_dummy = vol_wr_data_i[PCR_VDUMMY_HI:PCR_VDUMMY_LO];

    // Next configuration. The reload from the persistent word runs in the first cycle after reset and
    // beats a volatile write in that cycle, so no command can observe half-loaded settings.
    always_comb begin
        next_st = st;
        next_st.rd_valid = nv_rd_i;
        if (nv_rd_i) begin
            next_st.rd_data = nv_word;
        end
        if (st.load_pend) begin
            next_st.load_pend = 1'b0;
            next_st.dummy = (nv_dummy == PCR_DUMMY_ALIAS) ? PCR_DUMMY_DEFAULT : nv_dummy;
            next_st.exec_en = (nv_exec <= PCR_EXEC_LAST_MODE);
            next_st.exec_mode = nv_exec;
            next_st.dtr_en = ~nv_word[PCR_DTR_BIT];
            next_st.hold_en = nv_word[PCR_HOLD_BIT];
            next_st.quad = ~nv_word[PCR_QUAD_BIT];
            next_st.dual = ~nv_word[PCR_DUAL_BIT] & nv_word[PCR_QUAD_BIT];
            next_st.seg = nv_word[PCR_SEG_BIT] ? PCR_SEG_LOWEST : PCR_SEG_HIGHEST;
            next_st.addr4 = ~nv_word[PCR_ADDR_BIT];
            next_st.wrap = PCR_WRAP_CONT;
        end else begin
            if (vol_wr_i) begin
                next_st.dummy = (vol_dummy == PCR_DUMMY_ALIAS) ? PCR_DUMMY_DEFAULT : vol_dummy;
                next_st.exec_en = ~vol_wr_data_i[PCR_VEXEC_BIT];
                next_st.wrap = vol_wr_data_i[PCR_VWRAP_HI:PCR_VWRAP_LO];
            end
            if (seg_wr_i) begin
                next_st.seg = seg_wr_data_i;
            end
        end
        // In 4-byte mode the segment register plays no part in the address.
        if (st.addr4) begin
            next_st.mem_addr = cmd_addr_i[25:0];
        end else begin
            next_st.mem_addr = {st.seg, cmd_addr_i[23:0]};
        end
    end

    // State register; reset shows the erased-word settings until the reload lands.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st.load_pend <= 1'b1;
            st.dummy <= PCR_DUMMY_DEFAULT;
            st.exec_en <= 1'b0;
            st.exec_mode <= PCR_EXEC_OFF;
            st.dtr_en <= 1'b0;
            st.hold_en <= 1'b1;
            st.quad <= 1'b0;
            st.dual <= 1'b0;
            st.seg <= PCR_SEG_LOWEST;
            st.addr4 <= 1'b0;
            st.wrap <= PCR_WRAP_CONT;
            st.rd_data <= PCR_RD_RESET;
            st.rd_valid <= 1'b0;
            st.mem_addr <= PCR_ADDR_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Every output is a register field, so the command engine never sees the decode settle.
    assign nv_rd_data_o = st.rd_data;
    assign nv_rd_valid_o = st.rd_valid;
    assign mem_addr_o = st.mem_addr;
    assign dummy_cycles_o = st.dummy;
    assign execute_in_place_o = st.exec_en;
    assign execute_in_place_mode_o = st.exec_mode;
    assign dtr_enable_o = st.dtr_en;
    assign data_line_three_ctrl_o = st.hold_en;
    assign quad_proto_o = st.quad;
    assign dual_proto_o = st.dual;
    assign seg_sel_o = st.seg;
    assign addr_4byte_o = st.addr4;
    assign wrap_o = st.wrap;
    assign load_busy_o = st.load_pend;

    // All checks run on the one clock and stay silent while either reset is applied.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || por_i);

    // Checks on the configuration behaviour.
    a_nv_read_back: assert property (nv_rd_i && !nv_wr_i |=> nv_rd_valid_o && nv_rd_data_o == $past(nv_word))
        else $error("persistent word read returned wrong data");
    a_load_once: assert property (load_busy_o |=> !load_busy_o)
        else $error("reload did not finish in one cycle");
    a_dummy_alias: assert property (load_busy_o && nv_dummy == 4'h0 |=> dummy_cycles_o == 4'hf)
        else $error("dummy code zero not treated as default");
    a_dummy_load: assert property (load_busy_o && nv_dummy != 4'h0 |=> dummy_cycles_o == $past(nv_dummy))
        else $error("dummy count not loaded");
    a_exec_start: assert property (load_busy_o |=> execute_in_place_o == ($past(nv_exec) <= 3'h4))
        else $error("start-up execute mode wrong");
    a_exec_off: assert property (load_busy_o && nv_exec == 3'h7 |=> !execute_in_place_o)
        else $error("code 111 enabled execute mode");
    a_dtr_map: assert property (load_busy_o |=> dtr_enable_o != $past(nv_word[5]))
        else $error("double-rate bit mapped wrong");
    a_hold_map: assert property (load_busy_o |=> data_line_three_ctrl_o == $past(nv_word[4]))
        else $error("hold function bit mapped wrong");
    a_quad_wins: assert property (load_busy_o && nv_word[3:2] == 2'b00 |=> quad_proto_o && !dual_proto_o)
        else $error("quad protocol did not win over dual");
    a_dual_only: assert property (load_busy_o && nv_word[3:2] == 2'b10 |=> dual_proto_o && !quad_proto_o)
        else $error("dual protocol not selected");
    a_seg_start: assert property (load_busy_o |=> seg_sel_o == ($past(nv_word[1]) ? 2'h0 : 2'h3))
        else $error("power-on segment wrong");
    a_addr_mode: assert property (load_busy_o |=> addr_4byte_o != $past(nv_word[0]))
        else $error("address byte mode wrong");
    a_addr_seg: assert property (!addr_4byte_o |=> mem_addr_o[25:24] == $past(seg_sel_o))
        else $error("segment not on upper address bits");
    a_addr_full: assert property (addr_4byte_o |=> mem_addr_o == $past(cmd_addr_i[25:0]))
        else $error("segment used in 4-byte mode");
    a_vol_apply: assert property (vol_wr_i && !load_busy_o |=> wrap_o == $past(vol_wr_data_i[1:0])
        && execute_in_place_o == !$past(vol_wr_data_i[3]))
        else $error("volatile write not applied");

    // Checks on the volatile and segment paths and on settings that only a reload may change. Bus width,
    // address mode and start-up mode must hold still between resets, or a running command would break.
    a_vol_dummy: assert property (vol_wr_i && !load_busy_o && vol_wr_data_i[7:4] != 4'h0 |=>
        dummy_cycles_o == $past(vol_wr_data_i[7:4]))
        else $error("volatile dummy count not applied");
    a_vol_alias: assert property (vol_wr_i && !load_busy_o && vol_wr_data_i[7:4] == 4'h0 |=>
        dummy_cycles_o == 4'hf)
        else $error("volatile dummy code zero not treated as default");
    a_dummy_nonzero: assert property (dummy_cycles_o != 4'h0)
        else $error("dummy count of zero reached the output");
    a_proto_excl: assert property (!(quad_proto_o && dual_proto_o))
        else $error("quad and dual protocol active together");
    a_dual_none: assert property (load_busy_o && nv_word[2] |=> !dual_proto_o)
        else $error("dual protocol on with its bit high");
    a_mode_load: assert property (load_busy_o |=> execute_in_place_mode_o == $past(nv_exec))
        else $error("start-up mode code not loaded");
    a_cfg_frozen: assert property (!load_busy_o |=> $stable({dtr_enable_o, quad_proto_o, dual_proto_o}))
        else $error("protocol setting changed between resets");
    a_addr_frozen: assert property (!load_busy_o |=> $stable({data_line_three_ctrl_o, addr_4byte_o}))
        else $error("pin function or address mode changed between resets");
    a_mode_frozen: assert property (!load_busy_o |=> $stable(execute_in_place_mode_o))
        else $error("start-up mode code changed between resets");
    a_read_pulse: assert property (!nv_rd_i |=> !nv_rd_valid_o)
        else $error("read answer without a read");
    a_read_hold: assert property (!nv_rd_i |=> $stable(nv_rd_data_o))
        else $error("read data moved without a read");
    a_seg_write: assert property (seg_wr_i && !load_busy_o |=> seg_sel_o == $past(seg_wr_data_i))
        else $error("segment write not applied");
    a_seg_hold: assert property (!seg_wr_i && !load_busy_o |=> $stable(seg_sel_o))
        else $error("segment changed without a write");
    a_addr_low: assert property (1'b1 |=> mem_addr_o[23:0] == $past(cmd_addr_i[23:0]))
        else $error("low address bits not passed through");
    a_load_single: assert property (!load_busy_o |=> !load_busy_o)
        else $error("reload ran again without a reset");

endmodule // pcr_config

/* File: tb/pcr_host_model.sv */
`timescale 1ns/10ps
// Host controller model that hands over finished commands as one-cycle strobes.
module pcr_host_model (
    // Clock and read answer.
    input wire logic clk_i,
    input wire logic [15:0] nv_rd_data_i,
    input wire logic nv_rd_valid_i,
    // Command strobes and payloads.
    output logic nv_wr_o,
    output logic nv_rd_o,
    output logic [15:0] nv_data_o,
    output logic vol_wr_o,
    output logic [7:0] vol_data_o,
    output logic seg_wr_o,
    output logic [1:0] seg_data_o
);
    // Idle at time zero, payloads parked on values no test expects.
    initial begin
        {nv_wr_o, nv_rd_o, vol_wr_o, seg_wr_o} = 4'h0;
        nv_data_o = 16'h5a5a;
        vol_data_o = 8'ha5;
        seg_data_o = 2'h2;
    end
    // Payloads flip after release so a stale value can never be taken.
    task automatic nv_write(input logic [15:0] d);
        @(posedge clk_i);
        #1 nv_data_o = d;
        nv_wr_o = 1'b1;
        @(posedge clk_i);
        #1 nv_wr_o = 1'b0;
        nv_data_o = ~d;
    endtask
    // The answer stands one cycle only, so it is sampled right away.
    task automatic nv_read(output logic [16:0] r);
        @(posedge clk_i);
        #1 nv_rd_o = 1'b1;
        @(posedge clk_i);
        #1 nv_rd_o = 1'b0;
        r = {nv_rd_valid_i, nv_rd_data_i};
    endtask
    task automatic vol_write(input logic [7:0] d);
        @(posedge clk_i);
        #1 vol_data_o = d;
        vol_wr_o = 1'b1;
        @(posedge clk_i);
        #1 vol_wr_o = 1'b0;
        vol_data_o = ~d;
    endtask
    task automatic seg_write(input logic [1:0] d);
        @(posedge clk_i);
        #1 seg_data_o = d;
        seg_wr_o = 1'b1;
        @(posedge clk_i);
        #1 seg_wr_o = 1'b0;
        seg_data_o = ~d;
    endtask
endmodule // pcr_host_model

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    import pcr_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic por_i = 1'b1;
    logic [31:0] cmd_addr = 32'hfeabcdef;
    logic nv_wr, nv_rd, vol_wr, seg_wr, nv_valid, x_on, dtr, hold, quad, dual, a4, busy;
    logic [15:0] nv_wdata, nv_rdata;
    logic [7:0] vol_data;
    logic [1:0] seg_data, seg, wrap;
    logic [25:0] mem_addr;
    logic [3:0] dummy;
    logic [2:0] mode;
    logic [16:0] rd;
    int fail_count = 0;
    int total_checks = 0;
    // Stored words with expected configuration, mode and address before and after segment 1 is written.
    // Dummy counts of 7 and 1 suit a slow host.
    logic [15:0] words [3] = '{16'h0000, 16'h7e3b, 16'h161d};
    logic [11:0] cfgs [3] = '{12'hfd7, 12'h728, 12'h1e6};
    logic [2:0] modes [3] = '{3'h0, 3'h7, 3'h3};
    logic [25:0] addr0 [3] = '{26'h2abcdef, 26'h0abcdef, 26'h3abcdef};
    logic [25:0] addr1 [3] = '{26'h2abcdef, 26'h1abcdef, 26'h1abcdef};
    wire [11:0] cfg = {dummy, x_on, dtr, hold, quad, dual, seg, a4};

    // Clock at 100 MHz.
    always #5 clk_i = ~clk_i;

    pcr_host_model host (.clk_i(clk_i), .nv_rd_data_i(nv_rdata), .nv_rd_valid_i(nv_valid), .nv_wr_o(nv_wr),
        .nv_rd_o(nv_rd), .nv_data_o(nv_wdata), .vol_wr_o(vol_wr), .vol_data_o(vol_data), .seg_wr_o(seg_wr),
        .seg_data_o(seg_data));
    pcr_config uut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .nv_wr_i(nv_wr), .nv_wr_data_i(nv_wdata),
        .nv_rd_i(nv_rd), .nv_rd_data_o(nv_rdata), .nv_rd_valid_o(nv_valid), .vol_wr_i(vol_wr),
        .vol_wr_data_i(vol_data), .seg_wr_i(seg_wr), .seg_wr_data_i(seg_data), .cmd_addr_i(cmd_addr),
        .mem_addr_o(mem_addr), .dummy_cycles_o(dummy), .execute_in_place_o(x_on), .execute_in_place_mode_o(mode),
        .dtr_enable_o(dtr), .data_line_three_ctrl_o(hold), .quad_proto_o(quad), .dual_proto_o(dual),
        .seg_sel_o(seg), .addr_4byte_o(a4), .wrap_o(wrap), .load_busy_o(busy));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Reset for 16 cycles; with power-on the stored word is wiped as well.
    task automatic do_reset(input logic p);
        rst_i = 1'b1;
        por_i = p;
        repeat (16) @(posedge clk_i);
        #1 chk(busy, 1'b1);
        rst_i = 1'b0;
        por_i = 1'b0;
        repeat (3) @(posedge clk_i);
        #1 chk(busy, 1'b0);
    endtask

    // Main sequence: store each word, reset, and look at what was loaded.
    initial begin
        do_reset(1'b1);
        host.nv_read(rd);
        chk({rd, cfg}, {17'h1ffff, 12'hf20});
        for (int i = 0; i < 3; i++) begin
            host.nv_write(words[i]);
            host.nv_read(rd);
            chk(rd, {1'b1, words[i]});
            do_reset(1'b0);
            chk(cfg, cfgs[i]);
            chk({mode, wrap}, {modes[i], 2'h3});
            @(posedge clk_i);
            #1 chk(mem_addr, addr0[i]);
            host.seg_write(2'h1);
            repeat (2) @(posedge clk_i);
            #1 chk(mem_addr, addr1[i]);
        end
        host.vol_write(8'h01);
        repeat (2) @(posedge clk_i);
        #1 chk({dummy, x_on, wrap}, {4'hf, 1'b1, 2'h1});
        host.vol_write(8'he8);
        repeat (2) @(posedge clk_i);
        #1 chk({dummy, x_on, wrap}, {4'he, 1'b0, 2'h0});
        do_reset(1'b0);
        chk({cfg, wrap}, {12'h1e6, 2'h3});
        cmd_addr = 32'h01234567;
        repeat (2) @(posedge clk_i);
        #1 chk(mem_addr, 26'h3234567);
        do_reset(1'b1);
        host.nv_read(rd);
        chk({rd, cfg}, {17'h1ffff, 12'hf20});
        report_and_stop();
    end
    // Watchdog so a hang still ends in the verdict.
    initial begin
        #200000;
        fail_count++;
        report_and_stop();
    end
endmodule // tb_top
